// *** rtl/uph_core.sv ***
// Transceiver side of the parallel transmit and receive handshake.
`timescale 1ns/100ps
`include "uph_consts.svh"
`default_nettype none
module uph_core
  import uph_pkg::*;
(
  input  wire logic         i_ref_clk,                 // 250 MHz clock.
  input  wire logic         i_rstn,                    // Async reset, low.
  input  wire logic         i_transmit_data_valid,     // Engine has data.
  input  wire logic [15:0]  i_tx_data_bus,             // Transmit data.
  input  wire logic         i_tx_high_valid,           // High byte valid.
  input  wire logic         i_speed_select,            // 0 HS, 1 FS.
  input  wire logic [1:0]   i_operational_mode_select, // Line mode.
  input  wire logic         i_bus_width_select,        // 1 selects 16 bit.
  input  wire uph_line_rx_t i_line_rx,                 // Line receive events.
  input  wire logic         i_line_tx_take,            // Line took word.
  output logic              o_if_tick,                 // Interface clock.
  output logic              o_transmit_accept_ready,   // Word accepted.
  output logic              o_receive_word_valid,      // Receive data valid.
  output logic [15:0]       o_receive_data_bus,        // Receive data.
  output logic              o_receive_in_progress,     // Packet underway.
  output logic              o_receive_fault,           // Receive error.
  output uph_line_tx_t      o_line_tx                  // Line transmit side.
);

  // --------------------------------------------------------------------------
  // Interface clock enable
  // --------------------------------------------------------------------------
  uph_state_t s_q;
  uph_state_t s_d;
  logic       tick;
  logic [3:0] div;
  logic       drive_ok;
  logic       ready;
  logic       sync_done;

  // Width selects the interface rate.
  assign div = s_q.wide ? 4'(`UPH_DIV_WIDE)
                        : 4'(`UPH_DIV_NARROW);

  uph_tick_div u_div (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_div     (div),
    .o_tick    (tick)
  );

  // --------------------------------------------------------------------------
  // Combinational handshake terms
  // --------------------------------------------------------------------------
  assign drive_ok = (i_operational_mode_select != `UPH_MODE_NODRIVE);
  assign ready = i_transmit_data_valid && drive_ok &&
                 (s_q.tx_st == UPH_TX_SEND) && !s_q.hold_full;
  assign sync_done = s_q.hs ? (s_q.dly <= 4'h1) : tick;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync_p = 1'b0;
    s_d.eop_p  = 1'b0;

    // The width strap is caught once, just after reset is released.
    if (!s_q.wide_set) begin
      s_d.wide     = (i_bus_width_select == `UPH_WIDTH_WIDE);
      s_d.wide_set = 1'b1;
    end

    // Transmit sequence.
    case (s_q.tx_st)
      UPH_TX_IDLE: begin
        if (tick && i_transmit_data_valid && drive_ok) begin
          s_d.hs    = (i_speed_select == `UPH_SPEED_HS);
          s_d.dly   = 4'(`UPH_HS_SYNC_CYC);
          s_d.tx_st = UPH_TX_WAIT;
        end
      end
      UPH_TX_WAIT: begin
        if (sync_done) begin
          s_d.sync_p = 1'b1;
          s_d.tx_st  = UPH_TX_SEND;
        end else begin
          s_d.dly = s_q.dly - 4'h1;
        end
      end
      UPH_TX_SEND: begin
        if (tick && ready) begin
          s_d.hold      = s_q.wide ? i_tx_data_bus
                        : (i_tx_data_bus & `UPH_LO_BYTE_MASK);
          s_d.hold_hi   = s_q.wide && i_tx_high_valid;
          s_d.hold_full = 1'b1;
        end else if (tick && !i_transmit_data_valid) begin
          s_d.tx_st = UPH_TX_EOP;
        end
      end
      UPH_TX_EOP: begin
        // The last word leaves the holding register before EOP starts.
        if (!s_q.hold_full) begin
          s_d.eop_p = 1'b1;
          s_d.tx_st = UPH_TX_IDLE;
        end
      end
      default: begin
        s_d.tx_st = UPH_TX_IDLE;
      end
    endcase
    if (i_line_tx_take && s_q.hold_full) begin
      s_d.hold_full = 1'b0;
    end

    // Receive side: sync, word and end events are held until the next interface tick; errors set the fault at once.
    if (i_line_rx.sync_det && !s_q.rx_act) begin
      s_d.rx_sync_pend = 1'b1;
    end
    if (i_line_rx.word_valid && s_q.rx_act) begin
      s_d.rx_buf  = i_line_rx.word;
      s_d.rx_pend = 1'b1;
    end
    if (s_q.rx_act && (i_line_rx.eop_det || i_line_rx.stuff_err)) begin
      s_d.rx_end_pend = 1'b1;
    end
    if (tick) begin
      s_d.rx_val = s_q.rx_pend;
      if (s_q.rx_pend) begin
        s_d.rx_out  = s_q.rx_buf;
        s_d.rx_pend = i_line_rx.word_valid && s_q.rx_act;
      end
      if (s_q.rx_end_pend && !s_q.rx_pend) begin
        s_d.rx_act      = 1'b0;
        s_d.rx_end_pend = 1'b0;
      end else if (s_q.rx_sync_pend && !s_q.rx_act) begin
        s_d.rx_act       = 1'b1;
        s_d.rx_sync_pend = 1'b0;
        s_d.rx_fault     = 1'b0;
      end
    end
    // An error in the cycle of the packet-start clear is still kept.
    if (i_line_rx.stuff_err || i_line_rx.rx_err) begin
      s_d.rx_fault = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_if_tick               = tick;
  assign o_transmit_accept_ready = ready;
  assign o_receive_word_valid    = s_q.rx_val;
  assign o_receive_data_bus      = s_q.rx_out;
  assign o_receive_in_progress   = s_q.rx_act;
  assign o_receive_fault         = s_q.rx_fault;

  always_comb begin
    o_line_tx.sync_start = s_q.sync_p;
    o_line_tx.eop_start  = s_q.eop_p;
    o_line_tx.word_full  = s_q.hold_full;
    o_line_tx.high_ok    = s_q.hold_hi;
    o_line_tx.word       = s_q.hold;
    o_line_tx.hs         = s_q.hs;
    o_line_tx.raw        = (i_operational_mode_select == `UPH_MODE_RAW);
    o_line_tx.drive_en   = drive_ok;
  end
endmodule
`default_nettype wire

// *** rtl/uph_consts.svh ***
// Constants for the transceiver parallel handshake block.
`ifndef UPH_CONSTS_SVH
`define UPH_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define UPH_REF_CLK_MHZ      250
`define UPH_IF_CLK_WIDE_MHZ  30
`define UPH_IF_CLK_NARROW_MHZ 60
`define UPH_DIV_WIDE   (`UPH_REF_CLK_MHZ / `UPH_IF_CLK_WIDE_MHZ)
`define UPH_DIV_NARROW (`UPH_REF_CLK_MHZ / `UPH_IF_CLK_NARROW_MHZ)
`define UPH_HS_BIT_RATE_MBPS 480
`define UPH_HS_SYNC_MIN_BITS 8
`define UPH_HS_SYNC_MAX_BITS 16
`define UPH_HS_SYNC_CYC ((`UPH_HS_SYNC_MIN_BITS * `UPH_REF_CLK_MHZ + \
  `UPH_HS_BIT_RATE_MBPS - 1) / `UPH_HS_BIT_RATE_MBPS)

// ----------------------------------------------------------------------------
// Field encodings and reset values
// ----------------------------------------------------------------------------
`define UPH_SPEED_HS     1'h0
`define UPH_SPEED_FS     1'h1
`define UPH_MODE_NORMAL  2'h0
`define UPH_MODE_NODRIVE 2'h1
`define UPH_MODE_RAW     2'h2
`define UPH_MODE_RSVD    2'h3
`define UPH_WIDTH_WIDE   1'h1
`define UPH_DATA_RST     16'h0000
`define UPH_LO_BYTE_MASK 16'h00ff

`endif

// *** rtl/uph_pkg.sv ***
// Types shared by the transceiver parallel handshake block.
package uph_pkg;

  typedef enum logic [1:0] {
    UPH_TX_IDLE = 2'b00,
    UPH_TX_WAIT = 2'b01,
    UPH_TX_SEND = 2'b10,
    UPH_TX_EOP  = 2'b11
  } uph_tx_st_t;

  typedef struct packed {
    logic        sync_det;
    logic        word_valid;
    logic [15:0] word;
    logic        eop_det;
    logic        stuff_err;
    logic        rx_err;
  } uph_line_rx_t;

  typedef struct packed {
    logic        sync_start;
    logic        eop_start;
    logic        word_full;
    logic        high_ok;
    logic [15:0] word;
    logic        hs;
    logic        raw;
    logic        drive_en;
  } uph_line_tx_t;

  typedef struct packed {
    uph_tx_st_t  tx_st;
    logic [3:0]  dly;
    logic        hs;
    logic        hold_full;
    logic        hold_hi;
    logic [15:0] hold;
    logic        sync_p;
    logic        eop_p;
    logic        wide;
    logic        wide_set;
    logic        rx_sync_pend;
    logic        rx_act;
    logic        rx_fault;
    logic        rx_pend;
    logic [15:0] rx_buf;
    logic        rx_val;
    logic [15:0] rx_out;
    logic        rx_end_pend;
  } uph_state_t;

endpackage

// *** rtl/uph_tick_div.sv ***
// Divider making a one-cycle enable pulse at the interface clock rate.
`timescale 1ns/100ps
`default_nettype none
module uph_tick_div (
  input  wire logic       i_ref_clk,  // Reference clock.
  input  wire logic       i_rstn,     // Asynchronous reset, active low.
  input  wire logic [3:0] i_div,      // Reference cycles per tick.
  output logic            o_tick      // One-cycle enable pulse.
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    if (cnt_q >= i_div - 4'h1) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_tick = (cnt_q == 4'h0);
endmodule
`default_nettype wire

// *** test/uph_core_properties.sv ***
// Port assertions for the transceiver handshake block.
`timescale 1ns/100ps
`default_nettype none
module uph_core_properties
  import uph_pkg::*;
(
  input wire logic         i_ref_clk,
  input wire logic         i_rstn,
  input wire logic         i_transmit_data_valid,
  input wire logic [15:0]  i_tx_data_bus,
  input wire logic         i_tx_high_valid,
  input wire logic         i_bus_width_select,
  input wire logic         i_speed_select,
  input wire logic [1:0]   i_operational_mode_select,
  input wire uph_line_rx_t i_line_rx,
  input wire logic         o_if_tick,
  input wire logic         o_transmit_accept_ready,
  input wire logic         o_receive_word_valid,
  input wire logic [15:0]  o_receive_data_bus,
  input wire logic         o_receive_in_progress,
  input wire logic         o_receive_fault,
  input wire uph_line_tx_t o_line_tx
);
  logic        go_q, run_q;
  logic [15:0] w_q;
  wire st = o_if_tick & i_transmit_data_valid & ~go_q & ~run_q &
            (i_operational_mode_select != 2'h1);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      go_q  <= 1'b0;
      run_q <= 1'b0;
      w_q   <= 16'h0000;
    end else begin
      go_q  <= (go_q | st) & ~o_line_tx.sync_start;
      run_q <= (run_q | o_line_tx.sync_start) & ~o_line_tx.eop_start;
      if (i_line_rx.word_valid) w_q <= i_line_rx.word;
    end
  end
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_start;
    st;
  endsequence
  AST_RDY_IDLE: assert property (
    !i_transmit_data_valid |-> !o_transmit_accept_ready) else $error("ready");
  AST_RDY_FULL: assert property (
    o_line_tx.word_full |-> !o_transmit_accept_ready) else $error("full");
  AST_LOAD: assert property (
    o_if_tick && o_transmit_accept_ready |=> o_line_tx.word_full &&
    (o_line_tx.word == ($past(i_tx_data_bus) &
    (i_bus_width_select ? 16'hffff : 16'h00ff))) &&
    (o_line_tx.high_ok == (i_bus_width_select && $past(i_tx_high_valid))))
    else $error("load");
  AST_HS_SYNC: assert property (
    s_start ##0 !i_speed_select |-> ##[4:6] o_line_tx.sync_start &&
    o_line_tx.hs) else $error("hs sync");
  AST_FS_SYNC: assert property (
    s_start ##0 (i_speed_select && i_bus_width_select) |-> ##[7:9]
    o_line_tx.sync_start && !o_line_tx.hs) else $error("fs sync");
  AST_FS_SYNC_NARROW: assert property (
    s_start ##0 (i_speed_select && !i_bus_width_select) |-> ##[3:5]
    o_line_tx.sync_start && !o_line_tx.hs) else $error("fs sync narrow");
  AST_EOP: assert property (
    run_q && o_if_tick && !i_transmit_data_valid && !o_line_tx.word_full &&
    !o_line_tx.eop_start |-> ##[1:16] o_line_tx.eop_start) else $error("eop");
  AST_MODE: assert property (
    o_line_tx.raw == (i_operational_mode_select == 2'h2) &&
    o_line_tx.drive_en == (i_operational_mode_select != 2'h1))
    else $error("mode");
  AST_RX_ON: assert property (
    i_line_rx.sync_det && !o_receive_in_progress |-> ##[1:9]
    o_receive_in_progress) else $error("rx on");
  AST_RX_WORD: assert property (
    i_line_rx.word_valid && o_receive_in_progress |=> ##[0:8]
    o_receive_word_valid && o_receive_data_bus == w_q) else $error("rx word");
  AST_RX_OFF: assert property (
    o_receive_in_progress && (i_line_rx.eop_det || i_line_rx.stuff_err)
    |-> ##[1:17] !o_receive_in_progress) else $error("rx off");
  AST_FAULT: assert property (
    (i_line_rx.stuff_err || i_line_rx.rx_err) |=>
    o_receive_fault) else $error("fault");
endmodule
bind uph_core uph_core_properties i_uph_core_properties (.*);
`default_nettype wire

// *** test/uph_engine_model.sv ***
// Engine model: feeds transmit words, latches receive words.
`timescale 1ns/100ps
`default_nettype none
module uph_engine_model (
  input  wire logic        i_clk,      // Clock.
  input  wire logic        i_rstn,     // Reset, active low.
  input  wire logic        i_tick,     // Interface clock enable.
  input  wire logic [3:0]  i_words,    // Words to send, 0 idles.
  input  wire logic        i_abort,    // Drop valid.
  input  wire logic [15:0] i_base,     // First word.
  input  wire logic        i_ready,    // Word accepted.
  input  wire logic        i_rx_valid, // Receive word valid.
  input  wire logic [15:0] i_rx_data,  // Receive word.
  output logic             o_valid,    // Transmit valid.
  output logic [15:0]      o_data,     // Transmit data.
  output logic [15:0]      o_rx_last   // Last receive word.
);
  logic [3:0] left_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_valid   <= 1'b0;
      o_data    <= 16'h0000;
      o_rx_last <= 16'h0000;
      left_q    <= 4'h0;
    end else if (i_tick) begin
      if (i_rx_valid) o_rx_last <= i_rx_data;
      if (!o_valid && i_words != 4'h0) begin
        o_valid <= 1'b1;
        o_data  <= i_base;
        left_q  <= i_words;
      end else if (o_valid && (i_abort || (i_ready && left_q == 4'h1))) begin
        o_valid <= 1'b0;
        o_data  <= ~o_data;
      end else if (o_valid && i_ready) begin
        o_data <= o_data + 16'h0001;
        left_q <= left_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/uph_core_bench.sv ***
// Self-checking bench for the transceiver handshake block.
`timescale 1ns/100ps
`default_nettype none
module uph_core_bench;
  import uph_pkg::*;
  logic clk = 0, rstn = 0, hiv = 0, spd = 0, take = 0, ab = 0, wsel = 1;
  logic [1:0]   mode = 0;
  logic [3:0]   words = 0;
  logic [15:0]  base = 0;
  logic [31:0]  seed = 32'hc11b;
  uph_line_rx_t lrx = '0;
  uph_line_tx_t ltx;
  logic         tick, rdy, rxv, rxa, flt, txv;
  logic [15:0]  rxd, txd, last;
  int num_errors = 0, num_checks = 0, n_sync = 0, n_eop = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    n_sync += ltx.sync_start;
    n_eop  += ltx.eop_start;
  end
  uph_core i_uph_core (.i_ref_clk(clk), .i_rstn(rstn),
    .i_transmit_data_valid(txv), .i_tx_data_bus(txd), .i_tx_high_valid(hiv),
    .i_speed_select(spd), .i_operational_mode_select(mode),
    .i_bus_width_select(wsel), .i_line_rx(lrx), .i_line_tx_take(take),
    .o_if_tick(tick), .o_transmit_accept_ready(rdy),
    .o_receive_word_valid(rxv), .o_receive_data_bus(rxd),
    .o_receive_in_progress(rxa), .o_receive_fault(flt), .o_line_tx(ltx));
  uph_engine_model i_uph_engine_model (.i_clk(clk), .i_rstn(rstn),
    .i_tick(tick), .i_words(words), .i_abort(ab), .i_base(base),
    .i_ready(rdy), .i_rx_valid(rxv), .i_rx_data(rxd), .o_valid(txv),
    .o_data(txd), .o_rx_last(last));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // The narrow bus carries only the low byte of each word.
  function automatic logic [15:0] exp_word(input logic [15:0] w,
                                           input logic        wide);
    return wide ? w : (w & 16'h00ff);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tx_pkt(input logic [1:0] m, input logic [3:0] n);
    int k, t, s0, e0;
    seed = lfsr(seed);
    mode = m;
    spd = seed[0];
    hiv = seed[1];
    base = seed[17:2];
    s0 = n_sync;
    e0 = n_eop;
    cyc(1);
    chk(ltx.raw, m == 2'h2);
    chk(ltx.drive_en, m != 2'h1);
    words = n;
    k = 0;
    for (t = 0; k < n && t < (m == 2'h1 ? 40 : 2000); t++) begin
      cyc(1);
      if (txv) words = 0;
      if (ltx.word_full) begin
        chk(ltx.word, exp_word(base + 16'(k), wsel));
        chk(ltx.high_ok, hiv & wsel);
        cyc(seed[21:20]);
        k++;
        take = 1;
        cyc(1);
        take = 0;
        cyc(1);
      end
    end
    ab = (m == 2'h1);
    cyc(40);
    ab = 0;
    words = 0;
    chk(16'(k), m == 2'h1 ? 16'h0 : 16'(n));
    chk(16'(n_sync - s0), m != 2'h1);
    chk(16'(n_eop - e0), m != 2'h1);
  endtask
  task automatic rx_pkt(input logic [3:0] n, input logic [1:0] err);
    lrx.sync_det = 1;
    cyc(1);
    lrx.sync_det = 0;
    cyc(10);
    chk(rxa, 1);
    chk(flt, 0);
    repeat (n) begin
      seed = lfsr(seed);
      lrx.word = seed[15:0];
      lrx.word_valid = 1;
      cyc(1);
      lrx.word_valid = 0;
      lrx.word = ~seed[15:0];
      cyc(20);
      chk(last, seed[15:0]);
    end
    lrx.stuff_err = (err == 2'h1);
    lrx.rx_err = (err == 2'h2);
    lrx.eop_det = (err != 2'h1);
    cyc(1);
    lrx = '0;
    cyc(20);
    chk(rxa, 0);
    chk(flt, err != 2'h0);
  endtask
  initial begin
    cyc(8);
    rstn = 1;
    cyc(2);
    tx_pkt(2'h1, 4'h2);
    for (int i = 0; i < 8; i++) tx_pkt(i % 4 == 1 ? 2'h3 : 2'(i), 4'(i + 1));
    rx_pkt(4'h3, 2'h0);
    rx_pkt(4'h1, 2'h1);
    rx_pkt(4'h2, 2'h0);
    // A second reset selects the narrow bus, caught only at release.
    rstn = 0;
    wsel = 0;
    cyc(8);
    rstn = 1;
    cyc(2);
    for (int i = 0; i < 4; i++) tx_pkt(2'(i), 4'(i + 3));
    rx_pkt(4'h2, 2'h2);
    complete_run();
  end
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
